// file: logic/chgsf_pkg.sv
package chgsf_pkg;
	// Register map and fields
	localparam int          REG_AW       = 8;
	localparam int          REG_DW       = 8;
	localparam logic [7:0]  ADDR_FAULT   = 8'h00;
	localparam logic [7:0]  ADDR_FLOAT   = 8'h02;
	localparam logic [7:0]  ADDR_CUR     = 8'h04;
	localparam logic [7:0]  ADDR_SPC     = 8'h05;
	localparam logic [7:0]  ADDR_CEIL    = 8'h06;
	localparam int          FLT_MSB      = 2;
	localparam int          PH_MSB       = 5;
	localparam int          PH_LSB       = 4;
	localparam int          FLOAT_MSB    = 7;
	localparam int          FLOAT_LSB    = 2;
	localparam int          CUR_MSB      = 6;
	localparam int          CUR_LSB      = 4;
	localparam int          HOLD_BIT     = 4;
	localparam int          HTHR_MSB     = 2;
	localparam int          ICEIL_MSB    = 6;
	localparam int          ICEIL_LSB    = 4;
	localparam int          VCEIL_MSB    = 3;
	localparam logic [7:0]  CEIL_MASK    = 8'h7F;
	localparam logic [7:0]  CEIL_RST     = 8'h00;
	localparam logic [5:0]  FLOAT_RST    = 6'h00;
	localparam logic [2:0]  CUR_RST      = 3'h0;
	localparam logic [2:0]  HTHR_RST     = 3'h0;
	localparam logic [5:0]  FLOAT_BASE   = 6'h23;
	localparam logic [2:0]  CUR_FOLD     = 3'h0;
	// Fault codes and charge phase
	localparam logic [2:0]  FLT_NONE     = 3'h0;
	localparam logic [2:0]  FLT_OVP      = 3'h1;
	localparam logic [2:0]  FLT_SLEEP    = 3'h2;
	localparam logic [2:0]  FLT_UV       = 3'h3;
	localparam logic [2:0]  FLT_SHUT     = 3'h5;
	localparam logic [1:0]  PH_IDLE      = 2'h0;
	localparam logic [1:0]  PH_CHG       = 2'h1;
	localparam logic [1:0]  PH_FAULT     = 2'h3;
	// Timing
	localparam longint      CLK_HZ       = 10_000_000;
	localparam longint      VALID_MS     = 30;
	localparam longint      RETRY_MS     = 2000;
	localparam longint      PULSE_US     = 128;
	localparam int          VALID_CYC    = int'((VALID_MS * CLK_HZ + 999) / 1000);
	localparam int          RETRY_CYC    = int'((RETRY_MS * CLK_HZ + 999) / 1000);
	localparam int          PULSE_CYC_I  = int'((PULSE_US * CLK_HZ + 999_999) / 1_000_000);
	localparam int          TMR_W        = 25;
	localparam int          PCNT_W       = 11;
	localparam logic [10:0] PULSE_CYC    = PCNT_W'(PULSE_CYC_I);
	localparam int          NCMP         = 8;

	typedef enum logic [2:0] {ST_VALID, ST_CHARGE, ST_HOT, ST_UV, ST_OVP, ST_SLEEP} chgsf_state_e;
endpackage

// file: logic/chgsf_cmp_if.sv
`timescale 1ns/1ps
interface chgsf_cmp_if;
	logic hold;
	logic bat_ok;
	logic fold;
	logic shut;
	logic slp;
	logic vmin;
	logic ovp;
	logic ovp_clr;
	modport src (output hold, bat_ok, fold, shut, slp, vmin, ovp, ovp_clr);
	modport dst (input hold, bat_ok, fold, shut, slp, vmin, ovp, ovp_clr);
endinterface // chgsf_cmp_if

// file: logic/chgsf_sync.sv
`timescale 1ns/1ps
module chgsf_sync (
	input  wire logic                     clk_in,
	input  wire logic                     nrst_in,
	input  wire logic                     ce_in,
	input  wire logic [chgsf_pkg::NCMP-1:0] raw_in,
	chgsf_cmp_if.src                      cmp
);
	import chgsf_pkg::*;
	logic [NCMP-1:0] s1_ff;
	logic [NCMP-1:0] s2_ff;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s1_ff <= '0;
			s2_ff <= '0;
		end else if (ce_in) begin
			s1_ff <= raw_in;
			s2_ff <= s1_ff;
		end
	end

	assign {cmp.hold, cmp.bat_ok, cmp.fold, cmp.shut, cmp.slp, cmp.vmin, cmp.ovp, cmp.ovp_clr} = s2_ff;
endmodule // chgsf_sync

// file: logic/chgsf_timer.sv
`timescale 1ns/1ps
module chgsf_timer (
	input  wire logic                       clk_in,
	input  wire logic                       nrst_in,
	input  wire logic                       ce_in,
	input  wire logic                       run_in,
	input  wire logic [chgsf_pkg::TMR_W-1:0] limit_in,
	output logic                            done_out
);
	import chgsf_pkg::*;
	logic [TMR_W-1:0] cnt_ff;

	// Dropping run clears the count, so any break restarts the full interval
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_ff   <= '0;
			done_out <= 1'b0;
		end else if (ce_in) begin
			if (!run_in) begin
				cnt_ff   <= '0;
				done_out <= 1'b0;
			end else if (!done_out) begin
				cnt_ff   <= cnt_ff + 1'b1;
				done_out <= (cnt_ff == limit_in - 1'b1);
			end
		end
	end
endmodule // chgsf_timer

// file: logic/chgsf_top.sv
// Behaviour
// - Report hold-loop limiting in special register bit4
// - Three-bit hold threshold select in bits 2:0
// - Battery above short loads ceiling default
// - Other register write locks ceiling until short
// - Clamp float and current writes to ceiling
// - Ceiling holds current and voltage limits
// - Voltage limit is base code plus ceiling
// - Foldback forces lowest current code
// - Thermal shutdown suspends, fault 101, pulse
// - Suspend freezes timers, resumes when cool
// - Low input above minimum enters sleep
// - Input undervoltage ends charge, fault 011
// - Retry after interval once input recovers
// - Overvoltage opens switch, fault 001, pulse
// - Overvoltage clears on hysteresis, then revalidates
// - Fault code readable in register zero
// - Input must stay valid before charging
`timescale 1ns/1ps
module chgsf_top #(
	parameter int VALID_CYCLES = chgsf_pkg::VALID_CYC,
	parameter int RETRY_CYCLES = chgsf_pkg::RETRY_CYC
) (
	input  wire logic                        SYS_CLK_IN,
	input  wire logic                        NRST_IN,
	input  wire logic                        CE_IN,
	input  wire logic [chgsf_pkg::REG_AW-1:0] REG_ADDR_IN,
	input  wire logic [chgsf_pkg::REG_DW-1:0] REG_WDATA_IN,
	input  wire logic                        REG_WR_IN,
	input  wire logic                        REG_RD_IN,
	input  wire logic                        HOLD_LOOP_IN,
	input  wire logic                        BAT_ABOVE_SHORT_IN,
	input  wire logic                        TEMP_FOLD_IN,
	input  wire logic                        TEMP_SHUT_IN,
	input  wire logic                        VBUS_BELOW_SLEEP_IN,
	input  wire logic                        VBUS_ABOVE_MIN_IN,
	input  wire logic                        INPUT_OVERVOLTAGE_THRESHOLD_IN,
	input  wire logic                        INPUT_OVERVOLTAGE_THRESHOLD_CLR_IN,
	output logic [chgsf_pkg::REG_DW-1:0]     REG_RDATA_OUT,
	output logic                             CHARGE_EN_OUT,
	output logic                             INPUT_SWITCH_ON_OUT,
	output logic                             SLEEP_OUT,
	output logic                             TIMER_FREEZE_OUT,
	output logic                             COND_PULSE_OUT,
	output logic [1:0]                       CHG_PHASE_OUT,
	output logic [2:0]                       FAULT_CODE_OUT,
	output logic [2:0]                       CHG_CURRENT_CODE_OUT,
	output logic [5:0]                       FLOAT_VOLTAGE_CODE_OUT,
	output logic [2:0]                       INPUT_HOLD_THRESHOLD_OUT
);
	import chgsf_pkg::*;

	chgsf_cmp_if      cmp ();
	chgsf_state_e     state_ff;
	chgsf_state_e     nxt_state;
	logic [2:0]       fault_ff;
	logic [2:0]       nxt_fault;
	logic [1:0]       phase_ff;
	logic [1:0]       nxt_phase;
	logic             fire;
	logic [PCNT_W-1:0] pcnt_ff;
	logic             bat_prev_ff;
	logic             lock_ff;
	logic [7:0]       ceil_ff;
	logic [5:0]       float_ff;
	logic [2:0]       cur_ff;
	logic [2:0]       hthr_ff;
	logic [5:0]       vmax;
	logic [2:0]       imax;
	logic [5:0]       wfloat;
	logic [2:0]       wcur;
	logic             bat_rise;
	logic             wr_ceil;
	logic             wr_other;
	logic             sleep_cond;
	logic             freeze;
	logic             vtmr_run;
	logic             vtmr_done;
	logic             rtmr_run;
	logic             rtmr_done;

	// ----------------------------------------------------------------
	// Comparator synchronisers and timers
	// ----------------------------------------------------------------
	chgsf_sync u_sync (
		.clk_in  (SYS_CLK_IN),
		.nrst_in (NRST_IN),
		.ce_in   (CE_IN),
		.raw_in  ({HOLD_LOOP_IN, BAT_ABOVE_SHORT_IN, TEMP_FOLD_IN, TEMP_SHUT_IN,
		           VBUS_BELOW_SLEEP_IN, VBUS_ABOVE_MIN_IN, INPUT_OVERVOLTAGE_THRESHOLD_IN, INPUT_OVERVOLTAGE_THRESHOLD_CLR_IN}),
		.cmp     (cmp)
	);

	assign freeze   = (state_ff == ST_HOT);
	assign vtmr_run = (state_ff == ST_VALID) && cmp.vmin && !cmp.ovp && !freeze;
	assign rtmr_run = (state_ff == ST_UV) && !freeze;

	chgsf_timer u_valid_tmr (
		.clk_in   (SYS_CLK_IN),
		.nrst_in  (NRST_IN),
		.ce_in    (CE_IN),
		.run_in   (vtmr_run),
		.limit_in (TMR_W'(VALID_CYCLES)),
		.done_out (vtmr_done)
	);

	chgsf_timer u_retry_tmr (
		.clk_in   (SYS_CLK_IN),
		.nrst_in  (NRST_IN),
		.ce_in    (CE_IN),
		.run_in   (rtmr_run),
		.limit_in (TMR_W'(RETRY_CYCLES)),
		.done_out (rtmr_done)
	);

	// ----------------------------------------------------------------
	// Ceiling register and clamped settings
	// ----------------------------------------------------------------
	assign bat_rise = cmp.bat_ok && !bat_prev_ff;
	assign wr_ceil  = REG_WR_IN && (REG_ADDR_IN == ADDR_CEIL);
	assign wr_other = REG_WR_IN && (REG_ADDR_IN != ADDR_CEIL);
	assign vmax     = FLOAT_BASE + {2'b00, ceil_ff[VCEIL_MSB:0]};
	assign imax     = ceil_ff[ICEIL_MSB:ICEIL_LSB];
	assign wfloat   = REG_WDATA_IN[FLOAT_MSB:FLOAT_LSB];
	assign wcur     = REG_WDATA_IN[CUR_MSB:CUR_LSB];

	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			bat_prev_ff <= 1'b0;
			lock_ff     <= 1'b0;
		end else if (CE_IN) begin
			bat_prev_ff <= cmp.bat_ok;
			if (!cmp.bat_ok) begin
				lock_ff <= 1'b0;
			end else if (wr_other) begin
				lock_ff <= 1'b1;
			end
		end
	end

	// A write racing the battery rise is lost; the default must land first
	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ceil_ff <= CEIL_RST;
		end else if (CE_IN) begin
			if (bat_rise) begin
				ceil_ff <= CEIL_RST;
			end else if (wr_ceil && !lock_ff && cmp.bat_ok) begin
				ceil_ff <= REG_WDATA_IN & CEIL_MASK;
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			float_ff <= FLOAT_RST;
			cur_ff   <= CUR_RST;
			hthr_ff  <= HTHR_RST;
		end else if (CE_IN && REG_WR_IN) begin
			if (REG_ADDR_IN == ADDR_FLOAT) begin
				float_ff <= (wfloat > vmax) ? vmax : wfloat;
			end
			if (REG_ADDR_IN == ADDR_CUR) begin
				cur_ff <= (wcur > imax) ? imax : wcur;
			end
			if (REG_ADDR_IN == ADDR_SPC) begin
				hthr_ff <= REG_WDATA_IN[HTHR_MSB:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			REG_RDATA_OUT <= '0;
		end else if (CE_IN && REG_RD_IN) begin
			REG_RDATA_OUT <= '0;
			case (REG_ADDR_IN)
				ADDR_FAULT: begin
					REG_RDATA_OUT[FLT_MSB:0]     <= fault_ff;
					REG_RDATA_OUT[PH_MSB:PH_LSB] <= phase_ff;
				end
				ADDR_FLOAT: REG_RDATA_OUT[FLOAT_MSB:FLOAT_LSB] <= float_ff;
				ADDR_CUR:   REG_RDATA_OUT[CUR_MSB:CUR_LSB]     <= cur_ff;
				ADDR_SPC: begin
					REG_RDATA_OUT[HOLD_BIT]   <= cmp.hold;
					REG_RDATA_OUT[HTHR_MSB:0] <= hthr_ff;
				end
				ADDR_CEIL:  REG_RDATA_OUT <= ceil_ff;
				default:    REG_RDATA_OUT <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Fault sequencer
	// ----------------------------------------------------------------
	assign sleep_cond = cmp.slp && cmp.vmin;

	always_comb begin
		nxt_state = state_ff;
		nxt_fault = fault_ff;
		nxt_phase = phase_ff;
		fire      = 1'b0;
		case (state_ff)
			ST_VALID: begin
				if (sleep_cond) begin
					nxt_state = ST_SLEEP;
					nxt_fault = FLT_SLEEP;
				end else if (vtmr_done) begin
					nxt_state = ST_CHARGE;
					nxt_fault = FLT_NONE;
					nxt_phase = PH_CHG;
				end
			end
			ST_CHARGE: begin
				if (cmp.shut) begin
					nxt_state = ST_HOT;
					nxt_fault = FLT_SHUT;
					fire      = 1'b1;
				end else if (!cmp.vmin) begin
					nxt_state = ST_UV;
					nxt_fault = FLT_UV;
					nxt_phase = PH_FAULT;
					fire      = 1'b1;
				end else if (sleep_cond) begin
					nxt_state = ST_SLEEP;
					nxt_fault = FLT_SLEEP;
					nxt_phase = PH_IDLE;
				end
			end
			ST_HOT: begin
				// Everything else holds, so charging picks up where it stopped
				if (!cmp.shut) begin
					nxt_state = ST_CHARGE;
					nxt_fault = FLT_NONE;
				end
			end
			ST_UV: begin
				if (rtmr_done && cmp.vmin) begin
					nxt_state = ST_VALID;
					nxt_phase = PH_IDLE;
				end
			end
			ST_OVP: begin
				if (cmp.ovp_clr && !cmp.ovp) begin
					nxt_state = ST_VALID;
					nxt_fault = FLT_NONE;
					nxt_phase = PH_IDLE;
				end
			end
			ST_SLEEP: begin
				if (!sleep_cond) begin
					nxt_state = ST_VALID;
					nxt_fault = FLT_NONE;
				end
			end
			default: nxt_state = ST_VALID;
		endcase
		// Overvoltage outranks every other condition, even thermal suspend
		if (cmp.ovp && (state_ff != ST_OVP)) begin
			nxt_state = ST_OVP;
			nxt_fault = FLT_OVP;
			nxt_phase = PH_FAULT;
			fire      = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state_ff <= ST_VALID;
			fault_ff <= FLT_NONE;
			phase_ff <= PH_IDLE;
		end else if (CE_IN) begin
			state_ff <= nxt_state;
			fault_ff <= nxt_fault;
			phase_ff <= nxt_phase;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pcnt_ff        <= '0;
			COND_PULSE_OUT <= 1'b0;
		end else if (CE_IN) begin
			if (fire) begin
				pcnt_ff        <= PULSE_CYC - 1'b1;
				COND_PULSE_OUT <= 1'b1;
			end else if (pcnt_ff != '0) begin
				pcnt_ff <= pcnt_ff - 1'b1;
			end else begin
				COND_PULSE_OUT <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			CHARGE_EN_OUT            <= 1'b0;
			INPUT_SWITCH_ON_OUT      <= 1'b0;
			SLEEP_OUT                <= 1'b0;
			TIMER_FREEZE_OUT         <= 1'b0;
			CHG_PHASE_OUT            <= PH_IDLE;
			FAULT_CODE_OUT           <= FLT_NONE;
			CHG_CURRENT_CODE_OUT     <= CUR_RST;
			FLOAT_VOLTAGE_CODE_OUT   <= FLOAT_RST;
			INPUT_HOLD_THRESHOLD_OUT <= HTHR_RST;
		end else if (CE_IN) begin
			CHARGE_EN_OUT            <= (nxt_state == ST_CHARGE);
			INPUT_SWITCH_ON_OUT      <= (nxt_state != ST_OVP);
			SLEEP_OUT                <= (nxt_state == ST_SLEEP);
			TIMER_FREEZE_OUT         <= (nxt_state == ST_HOT);
			CHG_PHASE_OUT            <= nxt_phase;
			FAULT_CODE_OUT           <= nxt_fault;
			CHG_CURRENT_CODE_OUT     <= cmp.fold ? CUR_FOLD : cur_ff;
			FLOAT_VOLTAGE_CODE_OUT   <= float_ff;
			INPUT_HOLD_THRESHOLD_OUT <= hthr_ff;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!NRST_IN);

	AST_HOLD_FLAG: assert property (
		CE_IN && REG_RD_IN && (REG_ADDR_IN == ADDR_SPC) |=> REG_RDATA_OUT[HOLD_BIT] == $past(cmp.hold))
		else $error("hold flag not reported");
	AST_CEIL_LOAD: assert property (
		CE_IN && bat_rise |=> ceil_ff == CEIL_RST)
		else $error("ceiling default not loaded");
	AST_CEIL_LOCK: assert property (
		CE_IN && wr_ceil && lock_ff && !bat_rise |=> $stable(ceil_ff))
		else $error("locked ceiling changed");
	AST_FLOAT_CLAMP: assert property (
		CE_IN && REG_WR_IN && (REG_ADDR_IN == ADDR_FLOAT) |=> float_ff <= $past(vmax))
		else $error("float code above ceiling");
	AST_CUR_CLAMP: assert property (
		CE_IN && REG_WR_IN && (REG_ADDR_IN == ADDR_CUR) |=> cur_ff <= $past(imax))
		else $error("current code above ceiling");
	AST_FOLD: assert property (
		CE_IN && cmp.fold |=> CHG_CURRENT_CODE_OUT == CUR_FOLD)
		else $error("foldback not applied");
	AST_SHUT: assert property (
		CE_IN && (state_ff == ST_CHARGE) && cmp.shut && !cmp.ovp
		|=> (state_ff == ST_HOT) && (fault_ff == FLT_SHUT) && COND_PULSE_OUT && !CHARGE_EN_OUT)
		else $error("thermal shutdown sequence wrong");
	AST_FREEZE: assert property (
		(state_ff == ST_HOT) |-> TIMER_FREEZE_OUT && !CHARGE_EN_OUT && !vtmr_run && !rtmr_run)
		else $error("timer runs while suspended");
	AST_UV: assert property (
		CE_IN && (state_ff == ST_CHARGE) && !cmp.vmin && !cmp.shut && !cmp.ovp
		|=> (fault_ff == FLT_UV) && (phase_ff == PH_FAULT) && COND_PULSE_OUT)
		else $error("undervoltage sequence wrong");
	AST_OVP: assert property (
		CE_IN && cmp.ovp |=> (state_ff == ST_OVP) && (fault_ff == FLT_OVP) && !INPUT_SWITCH_ON_OUT)
		else $error("overvoltage sequence wrong");
	AST_VALID: assert property (
		(state_ff == ST_CHARGE) && ($past(state_ff) == ST_VALID) |-> $past(vtmr_done))
		else $error("charge started without validation");
	AST_PULSE: assert property (
		$rose(COND_PULSE_OUT) |-> COND_PULSE_OUT [*8])
		else $error("condition pulse too short");

	COV_HOT:   cover property ((state_ff == ST_HOT) ##1 (state_ff == ST_CHARGE));
	COV_RETRY: cover property ((state_ff == ST_UV) ##1 (state_ff == ST_VALID));
	COV_OVP:   cover property ((state_ff == ST_OVP) ##1 (state_ff == ST_VALID));
	COV_LOCK:  cover property (wr_ceil && lock_ff);
endmodule // chgsf_top

// file: sim/chgsf_host_model.sv
`timescale 1ns/1ps
module chgsf_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output logic [7:0]      addr_out,
	output logic [7:0]      wdata_out,
	output logic            wr_out,
	output logic            rd_out
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	// One strobe per access, changed just after the edge.
	// Stale write data is inverted once released.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		wdata_out = ~d;
	endtask

	// Data is registered at the taking edge, so it is settled just after it
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		rd_out = 1'b1;
		@(posedge clk_in);
		#1;
		rd_out = 1'b0;
		d = rdata_in;
	endtask
endmodule // chgsf_host_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
	import chgsf_pkg::*;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic [7:0] addr, wdata, rdata, d;
	logic       wr, rd;
	logic       hold = 1'b0, bat = 1'b0, fold = 1'b0, shut = 1'b0;
	logic       slp = 1'b0, vmin = 1'b1, ovp = 1'b0, ovp_clr = 1'b1;
	logic       ce = 1'b1;
	logic       chg_en, sw_on, sleep, frz, pulse;
	logic [1:0] phase;
	logic [2:0] fault, cur, thr;
	logic [5:0] flt_v;
	int         miscompares = 0;
	int         tests_run = 0;
	int         n;

	always #50 clk = ~clk;

	chgsf_top #(.VALID_CYCLES(20), .RETRY_CYCLES(30)) u_chgsf_top (
		.SYS_CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .HOLD_LOOP_IN(hold), .BAT_ABOVE_SHORT_IN(bat),
		.TEMP_FOLD_IN(fold), .TEMP_SHUT_IN(shut), .VBUS_BELOW_SLEEP_IN(slp), .VBUS_ABOVE_MIN_IN(vmin),
		.INPUT_OVERVOLTAGE_THRESHOLD_IN(ovp), .INPUT_OVERVOLTAGE_THRESHOLD_CLR_IN(ovp_clr), .REG_RDATA_OUT(rdata), .CHARGE_EN_OUT(chg_en),
		.INPUT_SWITCH_ON_OUT(sw_on), .SLEEP_OUT(sleep), .TIMER_FREEZE_OUT(frz), .COND_PULSE_OUT(pulse),
		.CHG_PHASE_OUT(phase), .FAULT_CODE_OUT(fault), .CHG_CURRENT_CODE_OUT(cur),
		.FLOAT_VOLTAGE_CODE_OUT(flt_v), .INPUT_HOLD_THRESHOLD_OUT(thr)
	);

	chgsf_host_model u_chgsf_host_model (
		.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		u_chgsf_host_model.rd(a, d);
		chk(d, exp);
	endtask

	// Bounded wait for a fault code and charge level; counts cycles spent
	task automatic wait_st(input logic [2:0] f, input logic c, output int k);
		k = 0;
		while (!(fault === f && chg_en === c) && k < 3000) begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k >= 3000) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, {chg_en, fault}, {c, f});
			summarize();
		end
	endtask

	// Synchroniser latency plus state update
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		#1;
		nrst = 1'b1;
		rchk(ADDR_CEIL, 8'h00);
		rchk(ADDR_FLOAT, 8'h00);
		rchk(ADDR_SPC, 8'h00);
		u_chgsf_host_model.wr(ADDR_CEIL, 8'h25);
		rchk(ADDR_CEIL, 8'h00);
		rchk(8'h07, 8'h00);
		// Battery above short: ceiling writable, then clamps
		bat = 1'b1;
		settle();
		u_chgsf_host_model.wr(ADDR_CEIL, 8'h25);
		rchk(ADDR_CEIL, 8'h25);
		u_chgsf_host_model.wr(ADDR_FLOAT, 8'hFC);
		rchk(ADDR_FLOAT, 8'hA0);
		chk({2'b00, flt_v}, 8'h28);
		u_chgsf_host_model.wr(ADDR_CUR, 8'h70);
		rchk(ADDR_CUR, 8'h20);
		u_chgsf_host_model.wr(ADDR_FLOAT, 8'h80);
		rchk(ADDR_FLOAT, 8'h80);
		u_chgsf_host_model.wr(ADDR_CEIL, 8'h7F);
		rchk(ADDR_CEIL, 8'h25);
		// Short event releases the lock and reloads the default
		bat = 1'b0;
		settle();
		bat = 1'b1;
		settle();
		rchk(ADDR_CEIL, 8'h00);
		u_chgsf_host_model.wr(ADDR_CEIL, 8'h7F);
		rchk(ADDR_CEIL, 8'h7F);
		u_chgsf_host_model.wr(ADDR_FLOAT, 8'hFC);
		rchk(ADDR_FLOAT, 8'hC8);
		u_chgsf_host_model.wr(ADDR_CUR, 8'h50);
		rchk(ADDR_CUR, 8'h50);
		// Hold loop flag and threshold
		hold = 1'b1;
		u_chgsf_host_model.wr(ADDR_SPC, 8'hFF);
		settle();
		rchk(ADDR_SPC, 8'h17);
		chk({5'h00, thr}, 8'h07);
		hold = 1'b0;
		settle();
		rchk(ADDR_SPC, 8'h07);
		// Charging after validation
		wait_st(FLT_NONE, 1'b1, n);
		chk({6'h00, phase}, {6'h00, PH_CHG});
		chk({5'h00, cur}, 8'h05);
		// Clock enable low freezes the synchroniser and the output
		ce = 1'b0;
		fold = 1'b1;
		settle();
		chk({5'h00, cur}, 8'h05);
		ce = 1'b1;
		settle();
		chk({5'h00, cur}, {5'h00, CUR_FOLD});
		rchk(ADDR_CUR, 8'h50);
		fold = 1'b0;
		settle();
		chk({5'h00, cur}, 8'h05);
		// Thermal shutdown and pulse length
		shut = 1'b1;
		wait_st(FLT_SHUT, 1'b0, n);
		chk({6'h00, frz, pulse}, 8'h03);
		rchk(ADDR_FAULT, {2'b00, PH_CHG, 1'b0, FLT_SHUT});
		// Pulse rose two edges before the read returned
		n = 2;
		while (pulse === 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(n[7:0], 8'h00);
		chk({5'h00, n[10:8]}, 8'h05);
		if (n >= 3000)
			summarize();
		chk({7'h00, frz}, 8'h01);
		shut = 1'b0;
		wait_st(FLT_NONE, 1'b1, n);
		chk({6'h00, frz, pulse}, 8'h00);
		chk({5'h00, cur}, 8'h05);
		// Input undervoltage and retry
		vmin = 1'b0;
		wait_st(FLT_UV, 1'b0, n);
		chk({5'h00, pulse, phase}, {5'h00, 1'b1, PH_FAULT});
		rchk(ADDR_FAULT, {2'b00, PH_FAULT, 1'b0, FLT_UV});
		vmin = 1'b1;
		wait_st(FLT_NONE, 1'b1, n);
		chk(8'(n >= 50), 8'h01);
		// Input overvoltage, hysteresis, revalidation
		ovp = 1'b1;
		ovp_clr = 1'b0;
		wait_st(FLT_OVP, 1'b0, n);
		chk({5'h00, sw_on, phase}, {6'h00, PH_FAULT});
		ovp = 1'b0;
		settle();
		chk({5'h00, fault}, {5'h00, FLT_OVP});
		ovp_clr = 1'b1;
		settle();
		chk({7'h00, sw_on}, 8'h01);
		wait_st(FLT_NONE, 1'b1, n);
		chk(8'(n >= 16), 8'h01);
		// Sleep entry and exit
		slp = 1'b1;
		wait_st(FLT_SLEEP, 1'b0, n);
		chk({7'h00, sleep}, 8'h01);
		slp = 1'b0;
		wait_st(FLT_NONE, 1'b1, n);
		chk({7'h00, sleep}, 8'h00);
		summarize();
	end
endmodule // tb
